//--- rtl/strap_latch_and_pin_select.sv
// strap capture, pin-select registers and address pin routing
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// - capture boot strap, decode four boot methods
// - capture four-bit memory config strap at reset
// - config bit 3 sets upper byte default
// - config bits 2:1 set bank-address-0 default
// - config bit 0 sets both address defaults
// - one bit switches address pins 13..3
// - rom boot drives active-low status on 61 in io mode
// - address pins 7..2 drive low in reset
// - one bit switches both sync pins
// - display enable pin select; output in reset
// - two-bit field pin function select
// - two-bit external clock pin function select
// - one bit selects video output clock pin
module strap_latch_and_pin_select
  import pin_select_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  // bus slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // shared address pins
  input  wire logic [13:8] addr_pin_in,
  output logic      [13:2] addr_pin_out,
  output logic      [13:2] addr_pin_oe,
  // core side of the address pins
  input  wire logic [13:2] mem_addr,
  input  wire logic [10:0] general_io_line_out,
  input  wire logic [10:0] general_io_line_oe,
  input  wire logic        boot_led_on,
  // latched strap results
  output logic [1:0]       boot_method_strap,
  output logic             rom_boot_mode,
  output logic             strap_valid,
  output logic             upper_data_byte_select,
  output logic [1:0]       bank_addr0_pin,
  output logic             low_addr_pin_select,
  output logic             mid_addr_pin_select,
  // video encoder side
  input  wire logic        enc_hsync,
  input  wire logic        enc_vsync,
  input  wire logic        enc_disp_oe,
  input  wire logic        enc_field,
  input  wire logic        enc_oclk,
  input  wire logic [5:0]  video_io_out,
  input  wire logic [5:0]  video_io_oe,
  input  wire logic        red2,
  input  wire logic        blue2,
  input  wire logic        pulse_3c,
  input  wire logic        pulse_3d,
  input  wire logic        external_clock_pin,
  output logic      [5:0]  video_pin_out,
  output logic      [5:0]  video_pin_oe,
  output logic             enc_ext_clk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [5:0]   strap_sync;       // 13:12 boot, 11:8 config
  logic         ext_clk_sync;     // external clock pin level
  boot_method_e boot_strap_r;     // latched boot method
  logic [3:0]   cfg_strap_r;      // latched memory config
  logic         strap_valid_r;    // set once after release
  logic         rom_boot_r;       // decoded rom boot flag
  logic [6:0]   video_sel_r;      // bits 22:16 of video select
  logic [4:0]   async_sel_r;      // bits 4:0 of async select
  logic         wr_pend_r;        // write data phase pending
  logic [31:0]  wr_addr_r;        // address of pending write
  logic [31:0]  hrdata_r;         // read data for data phase
  logic         hreadyout_r;      // always ready
  logic         hresp_r;          // always okay
  logic [31:0]  rd_word;          // read mux
  logic         take;             // address phase accepted
  logic         wr_video;         // write to video select
  logic         wr_async;         // write to async select

  // ****************************************************************
  // strap sampling
  // ****************************************************************
  // straps come from board resistors, asynchronous to clk
  sync2 #(
    .W (6)
  ) u_strap_sync (
    .clk (clk),
    .d   (addr_pin_in),
    .q   (strap_sync)
  );

  sync2 #(
    .W (1)
  ) u_xclk_sync (
    .clk (clk),
    .d   (external_clock_pin),
    .q   (ext_clk_sync)
  );

  // a reset shorter than three edges would latch unsettled values
  // latch once on the first edge after reset release;
  // reset must last three edges: one releases the strap pins, two fill the synchroniser
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      strap_valid_r <= 1'b0;
      boot_strap_r  <= BOOT_NAND;
      cfg_strap_r   <= 4'h0;
      rom_boot_r    <= 1'b0;
    end
    else if (!strap_valid_r)
    begin
      strap_valid_r <= 1'b1;
      boot_strap_r  <= boot_method_e'(strap_sync[5:4]);
      rom_boot_r    <= rom_boot(boot_method_e'(strap_sync[5:4]));
      cfg_strap_r   <= strap_sync[3:0];
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  // hready low means another transfer still owns the data phase
  // zero wait states: read data is ready in the data phase
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
  // a write lands at the end of its data phase
  assign wr_video = wr_pend_r && reg_hit(wr_addr_r, VIDEO_SEL_OFS);
  assign wr_async = wr_pend_r && reg_hit(wr_addr_r, ASYNC_SEL_OFS);

  // read mux; reserved and unmapped bits read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (reg_hit(haddr, VIDEO_SEL_OFS))
      rd_word[OCLK_SEL_BIT:SYNC_SEL_BIT] = video_sel_r;
    else if (reg_hit(haddr, ASYNC_SEL_OFS))
      rd_word[UPPER_BYTE_BIT:MID_ADDR_BIT] = async_sel_r;
    else if (reg_hit(haddr, STRAP_STAT_OFS))
    begin
      rd_word[STAT_CFG_LSB-1:STAT_BOOT_LSB] = boot_strap_r;
      rd_word[STAT_DONE_BIT-1:STAT_CFG_LSB] = cfg_strap_r;
      rd_word[STAT_DONE_BIT]                = strap_valid_r;
    end
  end

  // address phase capture and read data
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_pend_r   <= 1'b0;
      wr_addr_r   <= 32'h0000_0000;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
    else
    begin
      wr_pend_r   <= take && hwrite;
      wr_addr_r   <= haddr;
      // only full-word transfers are expected; hsize is not checked
      hrdata_r    <= (take && !hwrite) ? rd_word : 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

  // ****************************************************************
  // pin-select registers
  // ****************************************************************
  // video select: encoder functions after reset
  always_ff @(posedge clk)
  begin
    if (reset)
      video_sel_r <= VIDEO_SEL_RST;
    else if (wr_video)
      video_sel_r <= hwdata[OCLK_SEL_BIT:SYNC_SEL_BIT];
  end

  // the reserved bank code is kept so software reads back its write
  // async select: strap defaults, then software owns it
  always_ff @(posedge clk)
  begin
    if (reset)
      async_sel_r <= ASYNC_SEL_RST;
    else if (!strap_valid_r)
    begin
      // same synchroniser output as the strap latch
      async_sel_r[UPPER_BYTE_BIT] <= strap_sync[CFG_WIDTH_BIT];
      async_sel_r[BANK0_SEL_LSB+1:BANK0_SEL_LSB] <=
        strap_sync[CFG_BANK0_LSB+1:CFG_BANK0_LSB];
      async_sel_r[LOW_ADDR_BIT] <= strap_sync[CFG_ADDR_BIT];
      async_sel_r[MID_ADDR_BIT] <= strap_sync[CFG_ADDR_BIT];
    end
    else if (wr_async)
      async_sel_r <= hwdata[UPPER_BYTE_BIT:MID_ADDR_BIT];
  end

  assign boot_method_strap      = boot_strap_r;
  assign rom_boot_mode          = rom_boot_r;
  assign strap_valid            = strap_valid_r;
  assign upper_data_byte_select = async_sel_r[UPPER_BYTE_BIT];
  assign bank_addr0_pin = async_sel_r[BANK0_SEL_LSB+1:BANK0_SEL_LSB];
  assign low_addr_pin_select    = async_sel_r[LOW_ADDR_BIT];
  assign mid_addr_pin_select    = async_sel_r[MID_ADDR_BIT];

  // ****************************************************************
  // address pin routing
  // ****************************************************************
  // strap pins float as inputs and 7..2 drive low until the latch;
  // the reserved bank-address-0 code is stored but changes no pin here
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      addr_pin_out <= ADDR_OUT_RST;
      addr_pin_oe  <= ADDR_OE_RST;
    end
    else if (strap_valid_r)
    begin
      // pin 2 has no alternate function
      addr_pin_out[2] <= mem_addr[2];
      addr_pin_oe[2]  <= 1'b1;
      // one select moves all of 13..3 together
      if (async_sel_r[MID_ADDR_BIT])
      begin
        addr_pin_out[13:3] <= general_io_line_out;
        addr_pin_oe[13:3]  <= general_io_line_oe;
        // status lamp wins over software on line 61
        if (rom_boot_r)
        begin
          addr_pin_out[7] <= !boot_led_on;
          addr_pin_oe[7]  <= 1'b1;
        end
      end
      else
      begin
        addr_pin_out[13:3] <= mem_addr[13:3];
        addr_pin_oe[13:3]  <= 11'h7ff;
      end
    end
  end

  // ****************************************************************
  // video pin routing
  // ****************************************************************
  video_pin_router u_video (
    .clk          (clk),
    .reset        (reset),
    .sync_sel     (video_sel_r[SYNC_SEL_BIT-SYNC_SEL_BIT]),
    .disp_sel     (video_sel_r[DISP_OE_BIT-SYNC_SEL_BIT]),
    .field_sel    (video_sel_r[FIELD_SEL_LSB-SYNC_SEL_BIT+:2]),
    .xclk_sel     (video_sel_r[XCLK_SEL_LSB-SYNC_SEL_BIT+:2]),
    .oclk_sel     (video_sel_r[OCLK_SEL_BIT-SYNC_SEL_BIT]),
    .enc_hsync    (enc_hsync),
    .enc_vsync    (enc_vsync),
    .enc_disp_oe  (enc_disp_oe),
    .enc_field    (enc_field),
    .enc_oclk     (enc_oclk),
    .ext_clk_sync (ext_clk_sync),
    .io_out       (video_io_out),
    .io_oe        (video_io_oe),
    .red2         (red2),
    .blue2        (blue2),
    .pulse_3c     (pulse_3c),
    .pulse_3d     (pulse_3d),
    .pin_out      (video_pin_out),
    .pin_oe       (video_pin_oe),
    .enc_ext_clk  (enc_ext_clk)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  // all checks stay quiet in reset; the reset checks opt out
  boot_capture_a: assert property ($rose(strap_valid_r) |->
    boot_strap_r == $past(strap_sync[5:4]) &&
    rom_boot_r == ($past(strap_sync[5:4]) != 2'b01))
    else $error("boot strap not latched");
  cfg_capture_a: assert property ($rose(strap_valid_r) |->
    cfg_strap_r == $past(strap_sync[3:0]))
    else $error("config strap not latched");
  width_default_a: assert property ($rose(strap_valid_r) |->
    upper_data_byte_select == cfg_strap_r[3])
    else $error("bus width default wrong");
  bank0_default_a: assert property ($rose(strap_valid_r) |->
    bank_addr0_pin == cfg_strap_r[2:1])
    else $error("bank address 0 default wrong");
  addr_default_a: assert property ($rose(strap_valid_r) |->
    low_addr_pin_select == cfg_strap_r[0] &&
    mid_addr_pin_select == cfg_strap_r[0])
    else $error("address defaults wrong");
  mid_route_a: assert property (strap_valid_r &&
    !mid_addr_pin_select |=> addr_pin_oe[13:3] == 11'h7ff &&
    addr_pin_out[13:3] == $past(mem_addr[13:3]))
    else $error("address pins not on address function");
  led_drive_a: assert property (strap_valid_r && rom_boot_r &&
    mid_addr_pin_select |=> addr_pin_oe[7] &&
    addr_pin_out[7] == !$past(boot_led_on))
    else $error("boot status lamp not driven");
  reset_low_a: assert property (@(posedge clk) disable iff (1'b0)
    reset [*2] |-> addr_pin_oe[7:2] == 6'h3f &&
    addr_pin_out[7:2] == 6'h00 && addr_pin_oe[13:8] == 6'h00)
    else $error("address pins not low in reset");
  strap_hold_a: assert property (strap_valid_r |=>
    strap_valid_r && $stable(boot_strap_r) && $stable(cfg_strap_r))
    else $error("strap changed after latch");
  sw_override_a: assert property (wr_async && strap_valid_r |=>
    async_sel_r == $past(hwdata[4:0]))
    else $error("software write did not override");
  video_write_a: assert property (wr_video |=>
    video_sel_r == $past(hwdata[OCLK_SEL_BIT:SYNC_SEL_BIT]))
    else $error("video select write lost");
  // read data must not linger past its one data phase
  rd_idle_a: assert property (!(take && !hwrite) |=>
    hrdata == 32'h0000_0000)
    else $error("read data outside a read");

  flash_boot_c: cover property ($rose(strap_valid_r) &&
    boot_strap_r == BOOT_FLASH);
  led_path_c: cover property (rom_boot_r && mid_addr_pin_select
    ##1 !addr_pin_out[7]);
  sw_write_c: cover property (wr_video ##1 video_sel_r != 7'h00);
endmodule

//--- include/pin_select_pkg.sv
// package: register map, field layout, reset values and pin codes
package pin_select_pkg;
  // register byte addresses on the bus
  localparam logic [31:0] VIDEO_SEL_OFS  = 32'h0000_0000;
  localparam logic [31:0] ASYNC_SEL_OFS  = 32'h0000_0004;
  localparam logic [31:0] STRAP_STAT_OFS = 32'h0000_0008;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  // video pin-select fields
  localparam int SYNC_SEL_BIT  = 16;
  localparam int DISP_OE_BIT   = 17;
  localparam int FIELD_SEL_LSB = 18;
  localparam int XCLK_SEL_LSB  = 20;
  localparam int OCLK_SEL_BIT  = 22;
  // async pin-select fields
  localparam int MID_ADDR_BIT   = 0;
  localparam int LOW_ADDR_BIT   = 1;
  localparam int BANK0_SEL_LSB  = 2;
  localparam int UPPER_BYTE_BIT = 4;
  // strap status fields
  localparam int STAT_BOOT_LSB = 0;
  localparam int STAT_CFG_LSB  = 2;
  localparam int STAT_DONE_BIT = 6;
  // config strap bits
  localparam int CFG_ADDR_BIT  = 0;
  localparam int CFG_BANK0_LSB = 1;
  localparam int CFG_WIDTH_BIT = 3;
  // reset values
  localparam logic [6:0]  VIDEO_SEL_RST   = 7'h00;
  localparam logic [4:0]  ASYNC_SEL_RST   = 5'h00;
  localparam logic [11:0] ADDR_OUT_RST    = 12'h000;
  localparam logic [11:0] ADDR_OE_RST     = 12'h03f;
  localparam logic [5:0]  VIDEO_OE_RST    = 6'h04;
  // boot method strap codes
  typedef enum logic [1:0] {
    BOOT_NAND = 2'b00, BOOT_FLASH = 2'b01,
    BOOT_CARD = 2'b10, BOOT_SERIAL = 2'b11
  } boot_method_e;
  // video pin function codes
  typedef enum logic [1:0] {
    FN_ENCODER = 2'b00, FN_GENERAL_IO = 2'b01,
    FN_COLOUR = 2'b10, FN_PULSE = 2'b11
  } pin_fn_e;
  // word-aligned register hit
  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [31:0] ofs);
    return a[31:2] == ofs[31:2];
  endfunction
  // every boot method except flash runs from internal rom
  function automatic logic rom_boot(input boot_method_e m);
    return m != BOOT_FLASH;
  endfunction
endpackage

//--- rtl/sync2.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r; // first stage, read only by q
  // no reset: pins keep being sampled while reset is held
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule

//--- rtl/video_pin_router.sv
// routing of the six video control pins
`timescale 1ns/1ps
module video_pin_router
  import pin_select_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sync_sel,
  input  wire logic       disp_sel,
  input  wire logic [1:0] field_sel,
  input  wire logic [1:0] xclk_sel,
  input  wire logic       oclk_sel,
  input  wire logic       enc_hsync,
  input  wire logic       enc_vsync,
  input  wire logic       enc_disp_oe,
  input  wire logic       enc_field,
  input  wire logic       enc_oclk,
  input  wire logic       ext_clk_sync,
  input  wire logic [5:0] io_out,
  input  wire logic [5:0] io_oe,
  input  wire logic       red2,
  input  wire logic       blue2,
  input  wire logic       pulse_3c,
  input  wire logic       pulse_3d,
  output logic      [5:0] pin_out,
  output logic      [5:0] pin_oe,
  output logic            enc_ext_clk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // pin order: 0 hsync 1 vsync 2 display enable 3 field 4 ext clk 5 out clk
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_out     <= 6'h00;
      pin_oe      <= VIDEO_OE_RST; // display enable drives in reset
      enc_ext_clk <= 1'b0;
    end
    else
    begin
      // both sync pins follow one select
      pin_out[1:0] <= sync_sel ? io_out[1:0] : {enc_vsync, enc_hsync};
      pin_oe[1:0]  <= sync_sel ? io_oe[1:0] : 2'b11;
      pin_out[2]   <= disp_sel ? io_out[2] : enc_disp_oe;
      pin_oe[2]    <= disp_sel ? io_oe[2] : 1'b1;
      case (pin_fn_e'(field_sel))
        FN_ENCODER:
        begin
          pin_out[3] <= enc_field;
          pin_oe[3]  <= 1'b1;
        end
        FN_GENERAL_IO:
        begin
          pin_out[3] <= io_out[3];
          pin_oe[3]  <= io_oe[3];
        end
        FN_COLOUR:
        begin
          pin_out[3] <= red2;
          pin_oe[3]  <= 1'b1;
        end
        default:
        begin
          pin_out[3] <= pulse_3c;
          pin_oe[3]  <= 1'b1;
        end
      endcase
      // encoder function makes the pin an input
      case (pin_fn_e'(xclk_sel))
        FN_ENCODER:
        begin
          pin_out[4] <= 1'b0;
          pin_oe[4]  <= 1'b0;
        end
        FN_GENERAL_IO:
        begin
          pin_out[4] <= io_out[4];
          pin_oe[4]  <= io_oe[4];
        end
        FN_COLOUR:
        begin
          pin_out[4] <= blue2;
          pin_oe[4]  <= 1'b1;
        end
        default:
        begin
          pin_out[4] <= pulse_3d;
          pin_oe[4]  <= 1'b1;
        end
      endcase
      // level view only: a clock above 27 MHz must bypass this path
      enc_ext_clk <= (xclk_sel == FN_ENCODER) && ext_clk_sync;
      pin_out[5]  <= oclk_sel ? io_out[5] : enc_oclk;
      pin_oe[5]   <= oclk_sel ? io_oe[5] : 1'b1;
    end
  end

  sync_route_a: assert property (sync_sel |=>
    pin_out[1:0] == $past(io_out[1:0]) && pin_oe[1:0] == $past(io_oe[1:0]))
    else $error("sync pins not on general io");
  disp_reset_a: assert property (@(posedge clk) disable iff (1'b0)
    reset |=> pin_oe[2])
    else $error("display enable pin not driven in reset");
  field_route_a: assert property (field_sel == FN_COLOUR |=>
    pin_oe[3] && pin_out[3] == $past(red2))
    else $error("field pin not carrying red bit");
  xclk_in_a: assert property (xclk_sel == FN_ENCODER |=>
    !pin_oe[4] && enc_ext_clk == $past(ext_clk_sync))
    else $error("external clock pin not an input");
  oclk_route_a: assert property (!oclk_sel |=>
    pin_oe[5] && pin_out[5] == $past(enc_oclk))
    else $error("output clock pin not on encoder");
  pulse_3d_c: cover property (xclk_sel == FN_PULSE ##1 pin_oe[4]);
endmodule

//--- dv/strap_board.sv
// board model: strap resistors on the shared address pins 13..8
`timescale 1ns/1ps
// ******************************
// strap board
// ******************************
module strap_board (
  input  wire logic [5:0]  strap_level, // resistor levels, pins 13..8
  input  wire logic [13:2] pin_out,     // device drive value
  input  wire logic [13:2] pin_oe,      // device drive enable
  output logic      [13:8] pin_in       // resolved pin level
);
  // a driven pin shows the device value; a released pin falls back to
  // its resistor, never to the last driven level
  always_comb
  begin
    pin_in = (pin_out[13:8] & pin_oe[13:8]) | (strap_level & ~pin_oe[13:8]);
  end
endmodule

//--- dv/tb.sv
// self-checking bench for strap capture and pin selection
`timescale 1ns/1ps
module tb
  import pin_select_pkg::*;
;
  // ******************************
  // signals
  // ******************************
  logic        clk = 1'b0;                   // 40 mhz clock
  logic        reset = 1'b1;                 // sync reset
  logic        hsel = 1'b0;                  // bus select
  logic [31:0] haddr = 32'h0;                // bus address
  logic [1:0]  htrans = 2'h0;                // transfer type
  logic        hwrite = 1'b0;                // write flag
  logic [2:0]  hsize = 3'h2;                 // word size
  logic [31:0] hwdata = 32'h0;               // write data
  logic [31:0] hrdata;                       // read data
  logic        hreadyout;                    // slave ready
  logic        hresp;                        // slave response
  logic [5:0]  strap = 6'h0;                 // board resistors
  logic [13:8] addr_pin_in;                  // resolved strap pins
  logic [13:2] addr_pin_out;                 // address pin values
  logic [13:2] addr_pin_oe;                  // address pin enables
  logic [13:2] mem_addr = 12'ha5c;           // controller address
  logic [10:0] general_io_line_out = 11'h5b6; // io values, pin 7 high
  logic [10:0] general_io_line_oe = 11'h3ef;  // pin 7 enable low
  logic        boot_led_on = 1'b1;           // status lamp lit
  logic [1:0]  boot_method_strap;            // latched boot code
  logic        rom_boot_mode;                // rom boot flag
  logic        strap_valid;                  // strap latched
  logic        upper_data_byte_select;       // width select
  logic [1:0]  bank_addr0_pin;               // bank pin select
  logic        low_addr_pin_select;          // low address select
  logic        mid_addr_pin_select;          // mid address select
  logic [4:0]  enc = 5'b10101;               // oclk field oe vsync hsync
  logic [3:0]  alt = 4'b1001;                // 3d 3c blue2 red2
  logic [5:0]  video_io_out = 6'h1a;         // video io values
  logic [5:0]  video_io_oe = 6'h3e;          // video io enables
  logic        external_clock_pin = 1'b1;    // held high
  logic [5:0]  video_pin_out;                // video pin values
  logic [5:0]  video_pin_oe;                 // video pin enables
  logic        enc_ext_clk;                  // clock to encoder
  logic [31:0] rd;                           // last read word
  logic [1:0]  b;                            // boot code under test
  logic [3:0]  cf;                           // config under test
  int          fails = 0;                    // mismatches
  int          comparisons = 0;              // checks made
  // expected video pins for each select code, out already masked
  logic [5:0]  exp_oe [4] = '{6'h2f, 6'h3e, 6'h3f, 6'h3e};
  logic [5:0]  exp_vo [4] = '{6'h25, 6'h1a, 6'h2d, 6'h12};
  logic [31:0] vsel [4] = '{32'h0, 32'h57_0000, 32'h28_0000, 32'hffff_ffff};

  // free-running clock
  always #12.5 clk = ~clk;

  strap_board board (.strap_level(strap), .pin_out(addr_pin_out),
    .pin_oe(addr_pin_oe), .pin_in(addr_pin_in));

  strap_latch_and_pin_select DUT (.clk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
    .hresp, .addr_pin_in, .addr_pin_out, .addr_pin_oe, .mem_addr,
    .general_io_line_out, .general_io_line_oe, .boot_led_on,
    .boot_method_strap, .rom_boot_mode, .strap_valid,
    .upper_data_byte_select, .bank_addr0_pin, .low_addr_pin_select,
    .mid_addr_pin_select, .enc_hsync(enc[0]), .enc_vsync(enc[1]),
    .enc_disp_oe(enc[2]), .enc_field(enc[3]), .enc_oclk(enc[4]),
    .video_io_out, .video_io_oe, .red2(alt[0]), .blue2(alt[1]),
    .pulse_3c(alt[2]), .pulse_3d(alt[3]), .external_clock_pin,
    .video_pin_out, .video_pin_oe, .enc_ext_clk);

  // ******************************
  // tasks
  // ******************************
  // verdict and end of run
  task automatic complete_run();
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // bounded wait for ready; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      fails++;
      complete_run();
    end
  endtask

  // single word transfer: address phase, then data phase
  task automatic bus(input logic        w,
                     input logic [31:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // read and compare
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // address pins after the routing has settled
  task automatic chk_pins(input logic mid, input logic rom);
    logic [10:0] eo;
    logic [10:0] ee;
    eo = mid ? general_io_line_out : mem_addr[13:3];
    ee = general_io_line_oe;
    // lamp owns pin 7 only in io mode under rom boot
    if (mid && rom)
    begin
      eo[4] = ~boot_led_on;
      ee[4] = 1'b1;
    end
    repeat (3) @(posedge clk);
    chk({21'h0, addr_pin_out[13:3]}, {21'h0, eo});
    chk({31'h0, addr_pin_out[2]}, {31'h0, mem_addr[2]});
    chk({31'h0, addr_pin_oe[2]}, 32'h1);
    if (mid)
      chk({21'h0, addr_pin_oe[13:3]}, {21'h0, ee});
    else
      chk({21'h0, addr_pin_oe[13:3]}, 32'h7ff);
  endtask

  // ******************************
  // sequence
  // ******************************
  // hang guard
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run();
  end

  // main sequence: every boot code, every bank code, then overrides
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      b = i[1:0];
      cf = {b[1], b, b[0]};
      strap <= {b, cf};
      reset <= 1'b1;
      repeat (5) @(posedge clk);
      chk({20'h0, addr_pin_oe}, 32'h3f);
      chk({20'h0, addr_pin_out}, 32'h0);
      chk({26'h0, video_pin_oe}, 32'h4);
      chk({31'h0, strap_valid}, 32'h0);
      reset <= 1'b0;
      @(posedge clk);
      rd_chk(STRAP_STAT_OFS, {25'h0, 1'b1, cf, b});
      rd_chk(ASYNC_SEL_OFS,
        {27'h0, cf[3], cf[2:1], cf[0], cf[0]});
      chk({31'h0, strap_valid}, 32'h1);
      chk({30'h0, boot_method_strap}, {30'h0, b});
      chk({31'h0, rom_boot_mode}, {31'h0, b != 2'b01});
      chk({31'h0, upper_data_byte_select}, {31'h0, cf[3]});
      chk({30'h0, bank_addr0_pin}, {30'h0, cf[2:1]});
      chk({31'h0, low_addr_pin_select}, {31'h0, cf[0]});
      chk({31'h0, mid_addr_pin_select}, {31'h0, cf[0]});
      chk_pins(cf[0], b != 2'b01);
      // straps move after the latch; status must not
      strap <= ~strap;
      repeat (4) @(posedge clk);
      rd_chk(STRAP_STAT_OFS, {25'h0, 1'b1, cf, b});
    end
    // software override of strap defaults
    bus(1'b1, ASYNC_SEL_OFS, 32'hffff_ffea);
    rd_chk(ASYNC_SEL_OFS, 32'h0a);
    chk_pins(1'b0, 1'b1);
    chk({29'h0, upper_data_byte_select, bank_addr0_pin}, 32'h2);
    boot_led_on <= 1'b0;
    bus(1'b1, ASYNC_SEL_OFS, 32'h01);
    chk_pins(1'b1, 1'b1);
    // read-only status and an unmapped word
    bus(1'b1, STRAP_STAT_OFS, 32'h0);
    rd_chk(STRAP_STAT_OFS, 32'h7f);
    bus(1'b1, 32'h10, 32'hffff_ffff);
    rd_chk(32'h10, 32'h0);
    // every video function code
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, VIDEO_SEL_OFS, vsel[c]);
      rd_chk(VIDEO_SEL_OFS, vsel[c] & 32'h7f_0000);
      @(posedge clk);
      chk({26'h0, video_pin_oe},
        {26'h0, exp_oe[c]});
      chk({26'h0, video_pin_out & exp_oe[c]},
        {26'h0, exp_vo[c]});
      chk({31'h0, enc_ext_clk}, {31'h0, c == 0});
    end
    complete_run();
  end
endmodule
